// [hw/pm_pkg.sv]
// Shared types and constants for the Ethernet power-management block.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
package pm_pkg;

    // Clock and link settle time
    localparam longint unsigned CLK_HZ          = 64'd10000000;
    localparam longint unsigned LINK_SETTLE_MS  = 64'd300;
    localparam int              SETTLE_W        = 22;
    localparam logic [SETTLE_W-1:0] LINK_SETTLE_CYC =
        SETTLE_W'((LINK_SETTLE_MS * CLK_HZ) / 64'd1000);

    // PHY configuration store
    localparam int          PHY_ADDR_W     = 3;
    localparam int          PHY_DEPTH      = 8;
    localparam logic [15:0] PHY_RESET_WORD = 16'h0000;
    localparam logic [15:0] PHY_UNDEF_DATA = 16'hFFFF;

    // Reset values of status bits
    localparam logic ENERGY_FLAG_RST = 1'b1;
    localparam logic LINK_FLAG_RST   = 1'b0;

    // Power states
    typedef enum logic [3:0] {
        ST_OFF      = 4'h1,
        ST_PHY_DOWN = 4'h2,
        ST_SETTLE   = 4'h4,
        ST_LINKED   = 4'h8
    } pm_state_t;

    // Control bits written by the host
    typedef struct packed {
        logic crypto_engines_enable;
        logic receive_enable_bit;
        logic phy_sleep;
        logic ethernet_interface_enable;
        logic led_stretch_enable;
        logic energy_detect_powerdown_enable;
    } host_ctrl_t;

    // PHY register access from the host
    typedef struct packed {
        logic                  req;
        logic                  we;
        logic [PHY_ADDR_W-1:0] addr;
        logic [15:0]           wdata;
    } phy_access_t;

    // Enables handed to the rest of the controller
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic dma_enable;
        logic phy_powered;
        logic link_pulse_enable;
        logic led_stretch;
        logic crypto_enable;
        logic refclk_enable;
    } gate_t;

    // Status bits read by the host
    typedef struct packed {
        logic receive_in_progress;
        logic transmit_request;
        logic phy_link_up;
        logic link_change_flag;
        logic energy_detected_flag;
    } status_t;

endpackage

// [hw/pin_sync.sv]
// Three-flop synchroniser with agreement filter for one level from a pin.
// Assumes the input is asynchronous to i_clk.
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Pin and clean level
    input  wire logic i_pin,
    output logic      o_level
);

    logic meta_q;
    logic mid_q;
    logic late_q;

    // First flop feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q  <= RST_VAL;
            mid_q   <= RST_VAL;
            late_q  <= RST_VAL;
            o_level <= RST_VAL;
        end else begin
            meta_q <= i_pin;
            mid_q  <= meta_q;
            late_q <= mid_q;
            if (mid_q == late_q) begin
                o_level <= late_q;
            end
        end
    end

endmodule

// [hw/ethernet_power_management.sv]
// Power management of the Ethernet interface: general power-down, PHY
// sleep, link settle with transmit suppression and energy-detect sleep.
// Assumes host control bits and MAC strobes are on i_clk; the medium
// energy indication comes from the analog front end, asynchronous.

// Summary of operation
// - Host enters general power-down by clearing interface enable over commands.
// - In power-down no packet is sent or received and DMA stops.
// - Buffers and most registers keep contents and stay host accessible.
// - Reference clock output keeps running in every power state.
// - In power-down MAC/PHY registers are inaccessible and PHY registers clear.
// - Transmission is suppressed until the link settles after sleep.
// - Link changes set a sticky flag; link state is a status bit.
// - Energy-detect sleep keeps PHY configuration but passes no packets.
// - Energy flag sets on each arrival of signal on the medium.
// - Energy-detect enable powers the PHY from energy; clearing restores normal.
// - Unlinked in energy mode, transmit request stays set with no completion.
// - Energy-detect sleep sends no link pulses, only listens.
module ethernet_power_management #(
    parameter logic [pm_pkg::SETTLE_W-1:0] LINK_SETTLE_CYC = pm_pkg::LINK_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    // Host control bits and strobes
    input  wire pm_pkg::host_ctrl_t  i_ctrl,
    input  wire logic                i_tx_request_set,
    input  wire logic                i_link_flag_clear,
    input  wire logic                i_energy_flag_clear,
    // Host access to PHY configuration
    input  wire pm_pkg::phy_access_t i_phy_acc,
    output logic [15:0]              o_phy_rdata,
    output logic                     o_phy_rvalid,
    // MAC side
    input  wire logic                i_tx_done,
    input  wire logic                i_rx_frame_active,
    // Medium
    input  wire logic                i_medium_energy,
    // Enables and status
    output pm_pkg::gate_t            o_gate,
    output pm_pkg::status_t          o_status
);

    // Synchronised medium energy
    logic energy_s;

    pin_sync #(
        .RST_VAL (1'b0)
    ) u_energy_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_pin   (i_medium_energy),
        .o_level (energy_s)
    );

    // State and storage
    pm_pkg::pm_state_t               state_q;
    pm_pkg::pm_state_t               state_d;
    logic [pm_pkg::SETTLE_W-1:0]     settle_q;
    logic [pm_pkg::SETTLE_W-1:0]     settle_d;
    logic                            tx_req_q;
    logic                            link_q;
    logic                            link_flag_q;
    logic                            energy_flag_q;
    logic                            energy_seen_q;
    logic [15:0]                     phy_mem [pm_pkg::PHY_DEPTH];

    // Decoded conditions
    wire if_on        = i_ctrl.ethernet_interface_enable;
    wire ed_mode      = i_ctrl.energy_detect_powerdown_enable;
    wire ed_sleep     = ed_mode && !energy_s;
    wire phy_on       = if_on && !i_ctrl.phy_sleep && !ed_sleep;
    wire settle_done  = (settle_q == LINK_SETTLE_CYC - pm_pkg::SETTLE_W'(1));
    wire in_off       = (state_q == pm_pkg::ST_OFF);
    wire linked       = (state_q == pm_pkg::ST_LINKED);
    wire link_d       = (state_d == pm_pkg::ST_LINKED);
    wire energy_rise  = energy_s && !energy_seen_q;
    wire phy_acc_ok   = !in_off;
    wire phy_wr       = i_phy_acc.req && i_phy_acc.we && phy_acc_ok;
    wire phy_rd       = i_phy_acc.req && !i_phy_acc.we;
    wire tx_finish    = i_tx_done && o_gate.tx_enable;

    // Next power state
    always_comb begin
        state_d = state_q;
        case (state_q)
            pm_pkg::ST_OFF: begin
                if (if_on) begin
                    state_d = phy_on ? pm_pkg::ST_SETTLE : pm_pkg::ST_PHY_DOWN;
                end
            end
            pm_pkg::ST_PHY_DOWN: begin
                if (!if_on) begin
                    state_d = pm_pkg::ST_OFF;
                end else if (phy_on) begin
                    state_d = pm_pkg::ST_SETTLE;
                end
            end
            pm_pkg::ST_SETTLE: begin
                if (!if_on) begin
                    state_d = pm_pkg::ST_OFF;
                end else if (!phy_on) begin
                    state_d = pm_pkg::ST_PHY_DOWN;
                end else if (energy_s && settle_done) begin
                    state_d = pm_pkg::ST_LINKED;
                end
            end
            pm_pkg::ST_LINKED: begin
                if (!if_on) begin
                    state_d = pm_pkg::ST_OFF;
                end else if (!phy_on) begin
                    state_d = pm_pkg::ST_PHY_DOWN;
                end else if (!energy_s) begin
                    state_d = pm_pkg::ST_SETTLE;
                end
            end
            default: begin
                state_d = pm_pkg::ST_OFF;
            end
        endcase
    end

    // Settle timer restarts whenever the partner signal drops
    always_comb begin
        settle_d = '0;
        if (state_q == pm_pkg::ST_SETTLE && energy_s && !settle_done) begin
            settle_d = settle_q + pm_pkg::SETTLE_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q  <= pm_pkg::ST_OFF;
            settle_q <= '0;
        end else begin
            state_q  <= state_d;
            settle_q <= settle_d;
        end
    end

    // Transmit request: host sets, completion clears; set wins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_req_q <= 1'b0;
        end else if (i_tx_request_set) begin
            tx_req_q <= 1'b1;
        end else if (tx_finish) begin
            tx_req_q <= 1'b0;
        end
    end

    // Link state and sticky change flag; a new change beats the clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            link_q      <= 1'b0;
            link_flag_q <= pm_pkg::LINK_FLAG_RST;
        end else begin
            link_q <= link_d;
            if (link_d != link_q) begin
                link_flag_q <= 1'b1;
            end else if (i_link_flag_clear) begin
                link_flag_q <= 1'b0;
            end
        end
    end

    // Energy flag sets on each arrival of signal; set beats the clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            energy_seen_q <= 1'b0;
            energy_flag_q <= pm_pkg::ENERGY_FLAG_RST;
        end else begin
            energy_seen_q <= energy_s;
            if (energy_rise) begin
                energy_flag_q <= 1'b1;
            end else if (i_energy_flag_clear) begin
                energy_flag_q <= 1'b0;
            end
        end
    end

    // PHY configuration store, wiped while the interface is off
    // Kept in energy-detect sleep so the host need not reload it
    always_ff @(posedge i_clk) begin
        if (i_rst || in_off) begin
            for (int i = 0; i < pm_pkg::PHY_DEPTH; i++) begin
                phy_mem[i] <= pm_pkg::PHY_RESET_WORD;
            end
        end else if (phy_wr) begin
            phy_mem[i_phy_acc.addr] <= i_phy_acc.wdata;
        end
    end

    // Reads answer one cycle later; powered-down reads give junk
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_phy_rdata  <= pm_pkg::PHY_RESET_WORD;
            o_phy_rvalid <= 1'b0;
        end else begin
            o_phy_rvalid <= phy_rd;
            if (phy_rd) begin
                o_phy_rdata <= phy_acc_ok ? phy_mem[i_phy_acc.addr]
                                          : pm_pkg::PHY_UNDEF_DATA;
            end
        end
    end

    // Enables to the datapath, all registered
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_gate <= '0;
            o_gate.refclk_enable <= 1'b1;
        end else begin
            o_gate.tx_enable         <= (state_d == pm_pkg::ST_LINKED)
                                        && (tx_req_q || i_tx_request_set)
                                        && !tx_finish;
            o_gate.rx_enable         <= link_d && i_ctrl.receive_enable_bit;
            o_gate.dma_enable        <= if_on;
            o_gate.phy_powered       <= phy_on;
            o_gate.link_pulse_enable <= phy_on;
            o_gate.led_stretch       <= if_on && i_ctrl.led_stretch_enable;
            o_gate.crypto_enable     <= i_ctrl.crypto_engines_enable;
            o_gate.refclk_enable     <= 1'b1;
        end
    end

    // Status readback; receive activity is masked when no link
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_status <= '0;
            o_status.energy_detected_flag <= pm_pkg::ENERGY_FLAG_RST;
        end else begin
            o_status.receive_in_progress  <= i_rx_frame_active && linked;
            o_status.transmit_request     <= tx_req_q;
            o_status.phy_link_up          <= link_q;
            o_status.link_change_flag     <= link_flag_q;
            o_status.energy_detected_flag <= energy_flag_q;
        end
    end

endmodule

// [tb/pm_checker.sv]
// Port assertions for the power-management block.
// Assumes the single i_clk domain; bound into every instance of the block.
module pm_checker #(
    parameter logic [pm_pkg::SETTLE_W-1:0] LINK_SETTLE_CYC = pm_pkg::LINK_SETTLE_CYC
) (
    // Clock, reset and host side
    input wire logic                i_clk,
    input wire logic                i_rst,
    input wire pm_pkg::host_ctrl_t  i_ctrl,
    input wire logic                i_tx_request_set,
    input wire logic                i_link_flag_clear,
    input wire logic                i_energy_flag_clear,
    input wire pm_pkg::phy_access_t i_phy_acc,
    input wire logic [15:0]         o_phy_rdata,
    input wire logic                o_phy_rvalid,
    // MAC side, medium and outputs
    input wire logic                i_tx_done,
    input wire logic                i_rx_frame_active,
    input wire logic                i_medium_energy,
    input wire pm_pkg::gate_t       o_gate,
    input wire pm_pkg::status_t     o_status
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic en;
    assign en = i_ctrl.ethernet_interface_enable;
    refclk_on_a: assert property (o_gate.refclk_enable)
        else $error("refclk stopped");
    off_gates_a: assert property (!en [*2] |=> !(o_gate.tx_enable | o_gate.rx_enable | o_gate.dma_enable))
        else $error("traffic while off");
    read_valid_a: assert property (i_phy_acc.req && !i_phy_acc.we |=> o_phy_rvalid)
        else $error("read not answered");
    off_read_a: assert property (!en ##1 (!en && i_phy_acc.req && !i_phy_acc.we)
        |=> o_phy_rdata == 16'hFFFF) else $error("read while off");
    settle_tx_a: assert property ($rose(o_gate.phy_powered) |=> !o_gate.tx_enable [*8])
        else $error("tx during settle");
    tx_hold_a: assert property (o_status.transmit_request && !o_gate.tx_enable
        && !$past(o_gate.tx_enable) |=> o_status.transmit_request) else $error("request lost");
    energy_set_a: assert property ($rose(i_medium_energy) ##1
        (i_medium_energy && !i_energy_flag_clear) [*7] |=> o_status.energy_detected_flag)
        else $error("energy flag missing");
    link_flag_a: assert property ($changed(o_status.phy_link_up) |-> o_status.link_change_flag)
        else $error("link change unflagged");
    cover property (o_status.phy_link_up);
    cover property (o_status.transmit_request && i_ctrl.energy_detect_powerdown_enable);
    cover property ($fell(o_gate.phy_powered));
endmodule
bind ethernet_power_management pm_checker #(.LINK_SETTLE_CYC(LINK_SETTLE_CYC)) i_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_ctrl(i_ctrl), .i_tx_request_set(i_tx_request_set),
    .i_link_flag_clear(i_link_flag_clear), .i_energy_flag_clear(i_energy_flag_clear),
    .i_phy_acc(i_phy_acc), .o_phy_rdata(o_phy_rdata), .o_phy_rvalid(o_phy_rvalid),
    .i_tx_done(i_tx_done), .i_rx_frame_active(i_rx_frame_active),
    .i_medium_energy(i_medium_energy), .o_gate(o_gate), .o_status(o_status));

// [tb/host_model.sv]
// Host controller model sequencing the power control bits.
// Assumes status bits come from the block on the same clock.
module host_model (
    // Clock and status
    input  wire logic            i_clk,
    input  wire pm_pkg::status_t i_status,
    // Control bits and wait failure
    output pm_pkg::host_ctrl_t   o_ctrl,
    output logic                 o_stuck
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_ctrl = '0;
        o_stuck = 1'b0;
    end
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask
    task automatic power_down();
        int n;
        o_ctrl.crypto_engines_enable = 1'b0;
        tick();
        o_ctrl.receive_enable_bit = 1'b0;
        n = 0;
        while ((i_status.receive_in_progress | i_status.transmit_request) && n < 200) begin
            tick();
            n++;
        end
        o_stuck = (n == 200);
        o_ctrl.phy_sleep = 1'b1;
        tick();
        // Stretch drops with the enable so no LED is left lit
        o_ctrl.ethernet_interface_enable = 1'b0;
        o_ctrl.led_stretch_enable = 1'b0;
        tick();
    endtask
    task automatic wake();
        o_ctrl.ethernet_interface_enable = 1'b1;
        o_ctrl.led_stretch_enable = 1'b1;
        tick();
        o_ctrl.phy_sleep = 1'b0;
        tick();
        o_ctrl.receive_enable_bit = 1'b1;
        o_ctrl.crypto_engines_enable = 1'b1;
        tick();
    endtask
    task automatic set_ed(input logic on);
        o_ctrl.energy_detect_powerdown_enable = on;
        tick();
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench: host model drives control, bench drives MAC and medium.
// Assumes package, block, checker and host model compiled before it.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                clk, rst, tx_set, link_clr, ed_clr, tx_done, rx_act, energy;
    logic                stuck, rvalid;
    logic [15:0]         rdata, d;
    pm_pkg::host_ctrl_t  ctrl;
    pm_pkg::phy_access_t acc;
    pm_pkg::gate_t       gate;
    pm_pkg::status_t     st;
    int                  mismatches, n_checks, mem[8];
    always #50 clk = ~clk;
    // Short settle so the run stays brief
    ethernet_power_management #(.LINK_SETTLE_CYC(pm_pkg::SETTLE_W'(20))) i_dut (
        .i_clk(clk), .i_rst(rst), .i_ctrl(ctrl), .i_tx_request_set(tx_set),
        .i_link_flag_clear(link_clr), .i_energy_flag_clear(ed_clr), .i_phy_acc(acc),
        .o_phy_rdata(rdata), .o_phy_rvalid(rvalid), .i_tx_done(tx_done),
        .i_rx_frame_active(rx_act), .i_medium_energy(energy), .o_gate(gate), .o_status(st));
    host_model i_host (.i_clk(clk), .i_status(st), .o_ctrl(ctrl), .o_stuck(stuck));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_link(input logic v);
        int n;
        for (n = 0; n < 300 && st.phy_link_up !== v; n++) step(1);
        if (n == 300) begin
            mismatches++;
            end_of_test();
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(2);
    endtask
    task automatic phy(input logic we, input logic [2:0] a, input logic [15:0] v);
        acc = '{1'b1, we, a, v};
        step(1);
        if (!we) chk(16'(rvalid), 16'h0001);
        d = rdata;
        acc.req = 1'b0;
        step(1);
    endtask
    initial begin
        clk = 1'b0; rst = 1'b1; tx_set = 1'b0; link_clr = 1'b0; ed_clr = 1'b0;
        tx_done = 1'b0; rx_act = 1'b0; energy = 1'b1; acc = '0;
        mismatches = 0; n_checks = 0;
        void'($urandom(32'h175fd0a1));
        step(4);
        rst = 1'b0;
        step(1);
        chk(16'(gate), 16'h0001);
        chk(16'(st), 16'h0001);
        i_host.wake();
        wait_link(1'b1);
        chk(16'({st.link_change_flag, gate.rx_enable, gate.led_stretch}), 16'h0007);
        chk(16'(gate.crypto_enable), 16'h0001);
        pulse(link_clr);
        chk(16'(st.link_change_flag), 16'h0000);
        $display("test wake and link done");
        // Store model: random words, read back
        for (int i = 0; i < 8; i++) begin
            mem[i] = $urandom & 32'h0000FFFF;
            phy(1'b1, 3'(i), 16'(mem[i]));
        end
        for (int i = 0; i < 8; i++) begin
            phy(1'b0, 3'(i), 16'h0000);
            chk(d, 16'(mem[i]));
        end
        tx_set = 1'b1;
        step(1);
        tx_set = 1'b0;
        step(1);
        chk(16'({gate.tx_enable, st.transmit_request}), 16'h0003);
        pulse(tx_done);
        chk(16'({gate.tx_enable, st.transmit_request}), 16'h0000);
        $display("test store and transmit done");
        rx_act = 1'b1;
        fork
            begin
                step(8);
                rx_act = 1'b0;
            end
        join_none
        step(3);
        chk(16'(st.receive_in_progress), 16'h0001);
        i_host.power_down();
        step(2);
        chk(16'(stuck), 16'h0000);
        chk(16'(gate.crypto_enable), 16'h0000);
        chk(16'({gate.tx_enable, gate.rx_enable, gate.dma_enable, gate.refclk_enable}), 16'h0001);
        phy(1'b1, 3'd1, 16'h5A5A);
        phy(1'b0, 3'd1, 16'h0000);
        chk(d, pm_pkg::PHY_UNDEF_DATA);
        i_host.wake();
        phy(1'b0, 3'd1, 16'h0000);
        chk(d, 16'h0000);
        $display("test power down done");
        wait_link(1'b1);
        phy(1'b1, 3'd3, 16'hC3A5);
        i_host.set_ed(1'b1);
        energy = 1'b0;
        wait_link(1'b0);
        step(4);
        chk(16'({gate.phy_powered, gate.link_pulse_enable, st.link_change_flag}), 16'h0001);
        pulse(tx_set);
        step(20);
        chk(16'({st.transmit_request, gate.tx_enable}), 16'h0002);
        phy(1'b0, 3'd3, 16'h0000);
        chk(d, 16'hC3A5);
        pulse(ed_clr);
        chk(16'(st.energy_detected_flag), 16'h0000);
        energy = 1'b1;
        step(8);
        chk(16'(st.energy_detected_flag), 16'h0001);
        wait_link(1'b1);
        step(2);
        chk(16'({gate.phy_powered, gate.tx_enable}), 16'h0003);
        chk(16'({gate.dma_enable, gate.led_stretch}), 16'h0003);
        pulse(tx_done);
        chk(16'(st.transmit_request), 16'h0000);
        i_host.set_ed(1'b0);
        $display("test energy detect done");
        end_of_test();
    end
endmodule
